// ---- rtl/mld_map.svh ----
// Constants of the Manchester lock and ambiguity detector
`ifndef MLD_MAP_SVH
`define MLD_MAP_SVH

// Observation window, log2 of the symbol count
`define MLD_WIN_LOG2        14
// Lock threshold as a fraction of 2A, in thousandths (-5 dB point)
`define MLD_THR_MILLI       143
// Reference transition density the threshold is quoted for
`define MLD_DENS_REF_MILLI  500
// Scale of all thousandth figures
`define MLD_MILLI           1000
// Reset values
`define MLD_LOCK_RST        1'b0
`define MLD_BITCLK_RST      1'b0
// Transition codes: negative-going, none, positive-going
`define MLD_TR_NEG          2'sh1
`define MLD_TR_NONE         2'sh0
`define MLD_TR_POS          -2'sh1

`endif

// ---- rtl/mld_pkg.sv ----
// Types of the Manchester lock and ambiguity detector
package mld_pkg;

    // Verdict of the half-bit phase resolver
    typedef enum logic [1:0] {
        MLD_RES_UNKNOWN,
        MLD_RES_OK,
        MLD_RES_SLIP
    } mld_res_t;

    // Signed three-valued transition code
    typedef logic signed [1:0] mld_trans_t;

endpackage : mld_pkg

// ---- rtl/mld_arm.sv ----
// Integrate-and-discharge filter arm fed by converter samples
`timescale 1ns/1ps
module mld_arm #(
    parameter int SAMPLE_W = 8,
    parameter int ACC_W    = 16
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Samples
    input  wire logic signed [SAMPLE_W-1:0] sample_i,
    input  wire logic                      valid_i,
    // Window control
    input  wire logic                      en_i,
    input  wire logic                      neg_i,
    input  wire logic                      dump_i,
    // Result
    output logic signed [ACC_W-1:0]        sum_o,
    output logic                           done_o
);

    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] acc_nxt;
    logic signed [ACC_W-1:0] sum_nxt;
    logic                    done_nxt;
    logic signed [ACC_W-1:0] term;
    logic signed [ACC_W-1:0] acc_add;

    // Sign-flipped template gives the transition match
    always_comb begin
        term     = ACC_W'(sample_i);
        acc_add  = acc_r;
        if (en_i && valid_i) begin
            acc_add = neg_i ? acc_r - term : acc_r + term;
        end
        acc_nxt  = acc_add;
        sum_nxt  = sum_o;
        done_nxt = 1'b0;
        if (dump_i) begin
            // Sample of the dump cycle still counts
            sum_nxt  = acc_add;
            acc_nxt  = '0;
            done_nxt = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_r  <= '0;
            sum_o  <= '0;
            done_o <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            sum_o  <= sum_nxt;
            done_o <= done_nxt;
        end
    end

endmodule : mld_arm

// ---- rtl/mld_detector.sv ----
// Lock detector and half-bit ambiguity resolver, Manchester bit sync
`timescale 1ns/1ps
`include "mld_map.svh"

module mld_detector #(
    parameter int SAMPLE_W   = 8,
    parameter int ARM_W      = 16,
    parameter int WIN_LOG2   = `MLD_WIN_LOG2,
    parameter int AMP        = 1024,
    parameter int DENS_MILLI = `MLD_DENS_REF_MILLI
) (
    // Clock and reset
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       RST_N_I,
    // Converter samples
    input  wire logic signed [SAMPLE_W-1:0] SAMPLE_I,
    input  wire logic                       SAMPLE_VALID_I,
    // Timing generator of the phase detector
    input  wire logic                       HALF_END_I,
    input  wire logic                       TRANS_WIN_I,
    // Lock and phase status
    output logic                            LOCK_O,
    output logic                            AMB_OK_O,
    output logic                            SLIP_O,
    output logic                            WIN_DONE_O,
    output logic                            BIT_CLK_O,
    // Transition detector
    output logic signed [1:0]               TRANS_O,
    output logic                            TRANS_VLD_O,
    output logic                            TRANS_MID_O
);

    localparam int LACC_W = ARM_W + WIN_LOG2 + 2;
    localparam int AMB_W  = WIN_LOG2 + 3;
    // Threshold in sum units: 0.143*2A, rescaled for density
    localparam longint THR_L = (longint'(2) * AMP * `MLD_THR_MILLI
        * (`MLD_MILLI + `MLD_DENS_REF_MILLI))
        / (longint'(`MLD_MILLI) * (`MLD_MILLI + DENS_MILLI));
    localparam logic [LACC_W-1:0] LOCK_THR = LACC_W'(THR_L);

    // Magnitude of an arm result, widened for accumulation
    function automatic logic [LACC_W-1:0] mag_f(
        input logic signed [ARM_W-1:0] v
    );
        logic signed [ARM_W:0] w;
        w = (ARM_W+1)'(v);
        if (w < 0) begin
            w = -w;
        end
        return LACC_W'(unsigned'(w));
    endfunction : mag_f

    // Arm wiring
    logic signed [ARM_W-1:0] mid_sum;
    logic signed [ARM_W-1:0] btw_sum;
    logic signed [ARM_W-1:0] dat_sum;
    logic                    mid_done;
    logic                    btw_done;
    logic                    dat_done;
    logic                    win_rise;
    logic                    win_fall;
    logic                    route_mid;
    logic                    arm_neg;

    // Timing state
    logic                    win_d_r;
    logic                    win_d_nxt;
    logic                    win_mid_r;
    logic                    win_mid_nxt;
    logic                    post_r;
    logic                    post_nxt;
    logic                    half_sel_r;
    logic                    half_sel_nxt;
    logic                    ended_sel_r;
    logic                    ended_sel_nxt;
    logic                    slip_pend_r;
    logic                    slip_pend_nxt;
    logic                    sym_end;

    // Transition detector state
    logic                    a_prev_r;
    logic                    a_prev_nxt;
    logic                    have_prev_r;
    logic                    have_prev_nxt;
    logic                    a_cur;
    mld_pkg::mld_trans_t     trans_nxt;
    logic                    trans_vld_nxt;
    logic                    trans_mid_nxt;

    // Window accumulators and decisions
    logic [WIN_LOG2-1:0]     sym_cnt_r;
    logic [WIN_LOG2-1:0]     sym_cnt_nxt;
    logic [LACC_W-1:0]       lock_acc_r;
    logic [LACC_W-1:0]       lock_acc_nxt;
    logic [LACC_W-1:0]       contrib;
    logic [LACC_W-1:0]       avg;
    logic signed [AMB_W-1:0] amb_r;
    logic signed [AMB_W-1:0] amb_nxt;
    logic signed [AMB_W-1:0] amb_step;
    logic                    win_end;
    mld_pkg::mld_res_t       res_r;
    mld_pkg::mld_res_t       res_nxt;
    logic                    lock_nxt;
    logic                    amb_ok_nxt;
    logic                    slip_nxt;

    // Window edges and which boundary the window straddles
    always_comb begin
        win_rise  = TRANS_WIN_I & ~win_d_r;
        win_fall  = win_d_r & ~TRANS_WIN_I;
        // Window opened in a first half surrounds the mid-bit
        route_mid = win_rise ? ~half_sel_r : win_mid_r;
        arm_neg   = post_r | HALF_END_I;
    end

    // Mid-bit arm
    mld_arm #(
        .SAMPLE_W (SAMPLE_W),
        .ACC_W    (ARM_W)
    ) u_mid_arm (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .sample_i (SAMPLE_I),
        .valid_i  (SAMPLE_VALID_I),
        .en_i     (TRANS_WIN_I & route_mid),
        .neg_i    (arm_neg),
        .dump_i   (win_fall & win_mid_r),
        .sum_o    (mid_sum),
        .done_o   (mid_done)
    );

    // Between-bit arm
    mld_arm #(
        .SAMPLE_W (SAMPLE_W),
        .ACC_W    (ARM_W)
    ) u_btw_arm (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .sample_i (SAMPLE_I),
        .valid_i  (SAMPLE_VALID_I),
        .en_i     (TRANS_WIN_I & ~route_mid),
        .neg_i    (arm_neg),
        .dump_i   (win_fall & ~win_mid_r),
        .sum_o    (btw_sum),
        .done_o   (btw_done)
    );

    // Half-bit data integrator for hard decisions
    mld_arm #(
        .SAMPLE_W (SAMPLE_W),
        .ACC_W    (ARM_W)
    ) u_dat_arm (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .sample_i (SAMPLE_I),
        .valid_i  (SAMPLE_VALID_I),
        .en_i     (1'b1),
        .neg_i    (1'b0),
        .dump_i   (HALF_END_I),
        .sum_o    (dat_sum),
        .done_o   (dat_done)
    );

    // Half-bit phase and divide-by-two bit clock
    always_comb begin
        win_d_nxt     = TRANS_WIN_I;
        win_mid_nxt   = route_mid;
        post_nxt      = post_r;
        if (win_fall) begin
            post_nxt = 1'b0;
        end else if (HALF_END_I && TRANS_WIN_I) begin
            post_nxt = 1'b1;
        end
        half_sel_nxt  = half_sel_r;
        ended_sel_nxt = ended_sel_r;
        slip_pend_nxt = slip_pend_r;
        sym_end       = HALF_END_I & half_sel_r & ~slip_pend_r;
        if (HALF_END_I) begin
            ended_sel_nxt = half_sel_r;
            if (slip_pend_r) begin
                // Skipping one toggle moves the bit clock half a bit
                slip_pend_nxt = 1'b0;
            end else begin
                half_sel_nxt = ~half_sel_r;
            end
        end
        if (slip_nxt) begin
            slip_pend_nxt = 1'b1;
        end
    end

    // Hard decision transition detector
    always_comb begin
        // Negative integral is decision 1, so 0 to 1 is negative-going
        a_cur         = dat_sum < 0;
        a_prev_nxt    = a_prev_r;
        have_prev_nxt = have_prev_r;
        trans_nxt     = `MLD_TR_NONE;
        trans_vld_nxt = 1'b0;
        trans_mid_nxt = TRANS_MID_O;
        if (dat_done) begin
            a_prev_nxt    = a_cur;
            have_prev_nxt = 1'b1;
            trans_vld_nxt = have_prev_r;
            // Boundary before a second half is the mid-bit
            trans_mid_nxt = ended_sel_r;
            if (have_prev_r && a_cur != a_prev_r) begin
                trans_nxt = a_cur ? `MLD_TR_NEG : `MLD_TR_POS;
            end
        end
    end

    // Lock accumulation and ambiguity counting
    always_comb begin
        // Sum of both arm magnitudes is blind to a half-bit slip
        contrib = (mid_done ? mag_f(mid_sum) : '0)
                + (btw_done ? mag_f(btw_sum) : '0);
        amb_step = '0;
        if (trans_vld_nxt && trans_nxt != `MLD_TR_NONE) begin
            amb_step = trans_mid_nxt ? AMB_W'(1) : -AMB_W'(1);
        end
        win_end     = sym_end && (&sym_cnt_r);
        sym_cnt_nxt = sym_end ? sym_cnt_r + 1'b1 : sym_cnt_r;
        avg         = lock_acc_r >> WIN_LOG2;
        if (win_end) begin
            // Late arrivals open the new window
            lock_acc_nxt = contrib;
            amb_nxt      = amb_step;
        end else begin
            lock_acc_nxt = lock_acc_r + contrib;
            amb_nxt      = amb_r + amb_step;
        end
    end

    // Decisions at each window end
    always_comb begin
        lock_nxt   = LOCK_O;
        amb_ok_nxt = AMB_OK_O;
        slip_nxt   = 1'b0;
        res_nxt    = res_r;
        if (win_end) begin
            // Equal to threshold keeps the previous decision
            if (avg > LOCK_THR) begin
                lock_nxt = 1'b1;
            end else if (avg < LOCK_THR) begin
                lock_nxt = 1'b0;
            end
            if (amb_r > 0) begin
                res_nxt = mld_pkg::MLD_RES_OK;
            end else begin
                res_nxt = mld_pkg::MLD_RES_SLIP;
            end
        end
        case (res_nxt)
            mld_pkg::MLD_RES_OK: begin
                amb_ok_nxt = 1'b1;
            end
            mld_pkg::MLD_RES_SLIP: begin
                amb_ok_nxt = 1'b0;
                slip_nxt   = win_end;
            end
            mld_pkg::MLD_RES_UNKNOWN: begin
                amb_ok_nxt = 1'b0;
            end
            default: begin
                amb_ok_nxt = 1'b0;
            end
        endcase
    end

    // All state registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            win_d_r     <= 1'b0;
            win_mid_r   <= 1'b0;
            post_r      <= 1'b0;
            half_sel_r  <= `MLD_BITCLK_RST;
            ended_sel_r <= 1'b0;
            slip_pend_r <= 1'b0;
            a_prev_r    <= 1'b0;
            have_prev_r <= 1'b0;
            sym_cnt_r   <= '0;
            lock_acc_r  <= '0;
            amb_r       <= '0;
            res_r       <= mld_pkg::MLD_RES_UNKNOWN;
            LOCK_O      <= `MLD_LOCK_RST;
            AMB_OK_O    <= 1'b0;
            SLIP_O      <= 1'b0;
            WIN_DONE_O  <= 1'b0;
            BIT_CLK_O   <= `MLD_BITCLK_RST;
            TRANS_O     <= `MLD_TR_NONE;
            TRANS_VLD_O <= 1'b0;
            TRANS_MID_O <= 1'b0;
        end else begin
            win_d_r     <= win_d_nxt;
            win_mid_r   <= win_mid_nxt;
            post_r      <= post_nxt;
            half_sel_r  <= half_sel_nxt;
            ended_sel_r <= ended_sel_nxt;
            slip_pend_r <= slip_pend_nxt;
            a_prev_r    <= a_prev_nxt;
            have_prev_r <= have_prev_nxt;
            sym_cnt_r   <= sym_cnt_nxt;
            lock_acc_r  <= lock_acc_nxt;
            amb_r       <= amb_nxt;
            res_r       <= res_nxt;
            LOCK_O      <= lock_nxt;
            AMB_OK_O    <= amb_ok_nxt;
            SLIP_O      <= slip_nxt;
            WIN_DONE_O  <= win_end;
            BIT_CLK_O   <= half_sel_nxt;
            TRANS_O     <= trans_nxt;
            TRANS_VLD_O <= trans_vld_nxt;
            TRANS_MID_O <= trans_mid_nxt;
        end
    end

endmodule : mld_detector

// ---- sim/mld_src.sv ----
// Far-side model: converter sample stream and half-bit timing
`timescale 1ns/1ps
module mld_src (
    // Clock and control
    input  wire logic         clk_i,
    input  wire logic         run_i,
    input  wire logic         first_mid_i,
    input  wire logic         const_i,
    input  wire logic [7:0]   amp_i,
    // Samples and timing
    output logic signed [7:0] sample_o,
    output logic              valid_o,
    output logic              half_end_o,
    output logic              win_o
);
    logic [2:0] pos;
    logic       half;
    logic       bit_v;
    logic       go;

    initial begin
        sample_o   = 8'sh55;
        valid_o    = 1'b0;
        half_end_o = 1'b0;
        win_o      = 1'b0;
    end

    // Eight-cycle half bit; new level appears on the half-end cycle
    always @(posedge clk_i) begin
        go = run_i;
        #1;
        if (!go) begin
            pos        = 3'h1;
            half       = ~first_mid_i;
            bit_v      = 1'b1;
            valid_o    = 1'b0;
            half_end_o = 1'b0;
            win_o      = 1'b0;
            sample_o   = ~sample_o; // Idle bus, no stale level
        end else begin
            pos = pos + 3'h1;
            if (pos == 3'h7) begin
                half = ~half;
                if (!half) begin
                    bit_v = const_i | ~bit_v;
                end
            end
            sample_o   = (bit_v ^ half) ? $signed(amp_i) : -$signed(amp_i);
            half_end_o = (pos == 3'h7);
            win_o      = (pos >= 3'h5) || (pos == 3'h0);
            valid_o    = 1'b1;
        end
    end
endmodule : mld_src

// ---- sim/mld_detector_assertions.sv ----
// Port checker of the lock and ambiguity detector
`timescale 1ns/1ps
module mld_detector_assertions #(
    parameter int WIN_LOG2 = 14
) (
    // Clock and reset
    input wire logic              CLK_SYS_I,
    input wire logic              RST_N_I,
    // Observed ports
    input wire logic              HALF_END_I,
    input wire logic              LOCK_O,
    input wire logic              AMB_OK_O,
    input wire logic              SLIP_O,
    input wire logic              WIN_DONE_O,
    input wire logic              BIT_CLK_O,
    input wire logic signed [1:0] TRANS_O,
    input wire logic              TRANS_VLD_O
);
    localparam int WIN_SYMS = 1 << WIN_LOG2;
    logic        seen_r, seen_nxt;
    logic        pend_r, pend_nxt;
    logic [31:0] sym_r, sym_nxt;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    // First half seen, slip pending, symbols since last window end
    always_comb begin
        seen_nxt = seen_r | HALF_END_I;
        pend_nxt = SLIP_O | (pend_r & ~HALF_END_I);
        sym_nxt  = WIN_DONE_O ? 32'h0 : sym_r;
        if (HALF_END_I && BIT_CLK_O && !pend_r) begin
            sym_nxt = sym_nxt + 32'h1;
        end
    end

    // Helper registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            seen_r <= 1'b0;
            pend_r <= 1'b0;
            sym_r  <= 32'h0;
        end else begin
            seen_r <= seen_nxt;
            pend_r <= pend_nxt;
            sym_r  <= sym_nxt;
        end
    end

    // Slip order only ever comes with a window end
    sequence s_slip_verdict;
        WIN_DONE_O && !AMB_OK_O;
    endsequence

    AST_TRANS_LATENCY: assert property (
        HALF_END_I && seen_r |-> ##2 TRANS_VLD_O)
        else $error("Transition result missing after half end");
    AST_TRANS_CAUSE: assert property (
        TRANS_VLD_O |-> $past(HALF_END_I, 2))
        else $error("Transition result without half end");
    AST_TRANS_CODE: assert property (
        (TRANS_VLD_O || TRANS_O == 2'sh0) && TRANS_O != 2'sh2)
        else $error("Transition code out of range");
    AST_BITCLK_TOGGLE: assert property (
        HALF_END_I && !pend_r |=> BIT_CLK_O != $past(BIT_CLK_O))
        else $error("Bit clock did not toggle");
    AST_SLIP_HOLD: assert property (
        HALF_END_I && pend_r |=> $stable(BIT_CLK_O))
        else $error("Bit clock toggled during slip");
    AST_SLIP_VERDICT: assert property (
        SLIP_O |-> s_slip_verdict)
        else $error("Slip outside a failed window end");
    AST_VERDICT: assert property (
        WIN_DONE_O |-> SLIP_O || AMB_OK_O)
        else $error("Window end without verdict");
    AST_WIN_LEN: assert property (
        WIN_DONE_O |-> sym_r == WIN_SYMS)
        else $error("Window length wrong");
    AST_STATUS_HOLD: assert property (
        $changed(LOCK_O) || $changed(AMB_OK_O) |-> WIN_DONE_O)
        else $error("Status changed between window ends");
    AST_BITCLK_CAUSE: assert property (
        $changed(BIT_CLK_O) |-> $past(HALF_END_I))
        else $error("Bit clock moved without half end");
endmodule : mld_detector_assertions

bind mld_detector mld_detector_assertions #(
    .WIN_LOG2(WIN_LOG2)
) mld_detector_assertions_inst (
    .CLK_SYS_I  (CLK_SYS_I),
    .RST_N_I    (RST_N_I),
    .HALF_END_I (HALF_END_I),
    .LOCK_O     (LOCK_O),
    .AMB_OK_O   (AMB_OK_O),
    .SLIP_O     (SLIP_O),
    .WIN_DONE_O (WIN_DONE_O),
    .BIT_CLK_O  (BIT_CLK_O),
    .TRANS_O    (TRANS_O),
    .TRANS_VLD_O(TRANS_VLD_O)
);

// ---- sim/manchester_lock_ambiguity_detector_bench.sv ----
// Self-checking bench of the lock and ambiguity detector
`timescale 1ns/1ps
module manchester_lock_ambiguity_detector_bench;
    localparam int WIN_LOG2 = 3;
    localparam int AMP      = 400; // Threshold near 114 per symbol
    logic              clk_sys, rst_n, valid, half_end, trans_win;
    logic signed [7:0] sample;
    logic              lock, amb_ok, slip, win_done, bit_clk;
    logic signed [1:0] trans;
    logic              trans_vld, trans_mid;
    logic              run, first_mid, const_bit, chk_tr, exp_mid;
    logic [7:0]        amp;
    logic [2:0]        exp_q[$];
    int                fails, checked, cycles;

    // 200 MHz clock
    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    mld_src mld_src_inst (.clk_i(clk_sys), .run_i(run),
        .first_mid_i(first_mid), .const_i(const_bit), .amp_i(amp),
        .sample_o(sample), .valid_o(valid), .half_end_o(half_end),
        .win_o(trans_win));

    mld_detector #(.WIN_LOG2(WIN_LOG2), .AMP(AMP)) mld_detector_inst (
        .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .SAMPLE_I(sample),
        .SAMPLE_VALID_I(valid), .HALF_END_I(half_end),
        .TRANS_WIN_I(trans_win), .LOCK_O(lock), .AMB_OK_O(amb_ok),
        .SLIP_O(slip), .WIN_DONE_O(win_done), .BIT_CLK_O(bit_clk),
        .TRANS_O(trans), .TRANS_VLD_O(trans_vld), .TRANS_MID_O(trans_mid));

    task automatic stop_test();
        $display("Checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic cmp_win(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: verdict %b, expected %b", $time, got, exp);
        end
    endtask : cmp_win

    task automatic cmp_tr(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: code %b, expected %b", $time, got, exp);
        end
    endtask : cmp_tr

    // Reset mid-run, stream one phase, note verdicts {lock, ok, slip}
    task automatic run_test(input string name, input logic fm,
        input logic cb, input logic [7:0] v, input int nw,
        input logic [2:0] e1, input logic [2:0] e2);
        int n;
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        run = 1'b0;
        first_mid = fm;
        const_bit = cb;
        amp = v;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        run = 1'b1;
        chk_tr = cb;
        // First reported boundary of an aligned stream is the mid-bit
        exp_mid = 1'b1;
        exp_q.push_back(e1);
        if (nw > 1) begin
            exp_q.push_back(e2);
        end
        n = 0;
        while (exp_q.size() != 0 && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        #1;
        run = 1'b0;
        if (exp_q.size() != 0) begin
            fails++;
            $display("Error %0t: window end missing", $time);
            exp_q.delete();
        end
        $display("Test %s done", name);
    endtask : run_test

    // Verdicts and transition codes as they appear; hang guard last
    always @(posedge clk_sys) begin
        cycles++;
        if (rst_n && win_done === 1'b1) begin
            chk_tr = 1'b0;
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error %0t: unexpected window end", $time);
            end else begin
                cmp_win({lock, amb_ok, slip}, exp_q.pop_front());
            end
        end
        if (rst_n && chk_tr === 1'b1 && trans_vld === 1'b1) begin
            // Label alternates; mid is falling (+1), between rising (-1)
            cmp_tr({trans_mid, trans}, {exp_mid, ~exp_mid, 1'b1});
            exp_mid = ~exp_mid;
        end
        if (cycles > 8000) begin
            fails++;
            $display("Error %0t: timeout", $time);
            stop_test();
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        first_mid = 1'b1;
        const_bit = 1'b0;
        chk_tr = 1'b0;
        amp = 8'h28;
        fails = 0;
        checked = 0;
        cycles = 0;
        void'($urandom(17061));
        repeat (8) @(posedge clk_sys);
        run_test("aligned", 1'b1, 1'b0, 8'(36 + $urandom % 25), 2,
            3'h6, 3'h6);
        run_test("slipped", 1'b0, 1'b0, 8'(36 + $urandom % 25), 2,
            3'h5, 3'h6);
        run_test("tie", 1'b1, 1'b1, 8'h14, 1, 3'h5, 3'h0);
        run_test("weak", 1'b1, 1'b0, 8'(5 + $urandom % 18), 2,
            3'h2, 3'h2);
        run_test("weak_slip", 1'b0, 1'b0, 8'(5 + $urandom % 18), 2,
            3'h1, 3'h2);
        stop_test();
    end
endmodule : manchester_lock_ambiguity_detector_bench
